// ---- logic/ctrl_mem_map_and_cell_scheduler.sv ----
// host slave decode, control-memory and local-bus access, cell scheduler
// Operation
// - offsets 0000h-03FFh reach the 256-word initialization area, R/W
// - offsets 0400h-23FFh reach 2K-word transmit channel states, R/W
// - offsets 2400h-3FFFh reach the scheduling table, R/W
// - offsets 4000h-BFFFh reach 8K-word receive channel states, R/W
// - offsets C000h-DFFFh reach PHY registers over the local bus
// - offsets E000h-FFFFh reach internal user registers, R/W except the read-only status at E010h
// - indirect address and data registers reach any control-memory word
// - EPROM up to 8K bytes is readable over the local bus
// - PHY write passes the lowest byte marked by byte enables
// - PHY read byte is copied into all four lanes
// - control-memory word address is 14 offset bits of the address
// - region bases 0000h, 0100h, 0900h, 1000h in control memory
// - transmit buffering is at most nine cells, eight queued plus one in the output stage
// - device adds AAL5 encapsulation to every data cell
// - transmit any byte start; receive buffers 16-byte aligned
// - table has up to 4800 8-bit entries in 1200 words
// - active entry count comes from the table-size register
// - nonzero index names a bandwidth group; one cell per entry, cyclically
// - zero index sends an idle cell
// - device masters every payload transfer in both directions
// - local-bus access waits for the ready handshake
`default_nettype none

// --------
// slot fifo
// --------
module slot_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push, pop;

  assign in_ready = (count_reg != CW'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (!out_valid || out_ready) && (count_reg != '0);

  always_ff @(posedge ref_clk) begin
    if (push) mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end

  // registered output stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// --------
// top
// --------
module ctrl_mem_map_and_cell_scheduler
  import sar_map_pkg::*;
#(
  parameter int SLOT_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic host_req_valid,
  input wire host_req_type host_req,
  output logic host_ack,
  output logic [31:0] host_rdata,
  output logic [13:0] cm_addr,
  output logic [31:0] cm_wdata,
  output logic cm_data_oe,
  input wire logic [31:0] cm_rdata,
  output logic cm_we_n,
  output logic cm_oe_n,
  output logic [12:0] lb_addr,
  output logic [7:0] lb_wdata,
  output logic lb_data_oe,
  input wire logic [7:0] lb_rdata,
  output logic lb_rd_n,
  output logic lb_wr_n,
  output logic lb_phy_cs_n,
  output logic lb_rom_cs_n,
  input wire logic lb_ready,
  output logic cell_valid,
  output cell_slot_type cell_slot,
  input wire logic cell_ready,
  output logic [3:0] rx_buf_align_mask
);

  function automatic logic [1:0] low_lane(input logic [3:0] be);
    return be[0] ? 2'd0 : be[1] ? 2'd1 : be[2] ? 2'd2 : 2'd3;
  endfunction

  // --------
  // pin synchronisers
  // --------
  logic [2:0][31:0] cm_sync_reg;
  logic [2:0][7:0] lb_sync_reg;
  logic [2:0] lb_rdy_sync_reg;
  logic lb_rdy_high, lb_rdy_low;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cm_sync_reg <= '0;
      lb_sync_reg <= '0;
      lb_rdy_sync_reg <= '0;
    end else begin
      cm_sync_reg <= {cm_sync_reg[1:0], cm_rdata};
      lb_sync_reg <= {lb_sync_reg[1:0], lb_rdata};
      lb_rdy_sync_reg <= {lb_rdy_sync_reg[1:0], lb_ready};
    end
  end

  assign lb_rdy_high = lb_rdy_sync_reg[1] && lb_rdy_sync_reg[2];
  assign lb_rdy_low = !lb_rdy_sync_reg[1] && !lb_rdy_sync_reg[2];

  // --------
  // state and registers
  // --------
  slave_state_type state_reg;
  logic [31:0] ind_addr_reg, ind_data_reg;
  logic [12:0] tbl_size_reg, entry_reg, entry_next;
  logic sched_run_reg, sched_owner_reg, ind_owner_reg, cm_write_reg;
  logic lb_rom_reg, lb_write_reg, push_reg, fifo_in_ready;
  logic cm_data_ok, lb_data_ok;
  logic [2:0] cm_cnt_reg;
  logic [3:0] lb_be_reg;
  logic [1:0] lb_lane_reg;
  logic [10:0] lb_word_reg;
  cell_slot_type push_slot_reg;
  logic [7:0] tbl_byte;

  assign cm_data_ok = (cm_sync_reg[1] == cm_sync_reg[2]);
  assign lb_data_ok = (lb_sync_reg[1] == lb_sync_reg[2]);
  assign tbl_byte = cm_sync_reg[2][8*entry_reg[1:0] +: 8];
  assign entry_next = (entry_reg + 13'd1 >= tbl_size_reg) ? 13'd0
                      : entry_reg + 13'd1;

  // --------
  // slave and memory access sequencer
  // --------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      host_ack <= 1'b0;
      host_rdata <= '0;
      cm_addr <= '0;
      cm_wdata <= '0;
      cm_data_oe <= 1'b0;
      cm_we_n <= 1'b1;
      cm_oe_n <= 1'b1;
      lb_addr <= '0;
      lb_wdata <= '0;
      lb_data_oe <= 1'b0;
      lb_rd_n <= 1'b1;
      lb_wr_n <= 1'b1;
      lb_phy_cs_n <= 1'b1;
      lb_rom_cs_n <= 1'b1;
      ind_addr_reg <= RST_CM_ADDR;
      ind_data_reg <= RST_CM_DATA;
      tbl_size_reg <= RST_TBL_SIZE;
      sched_run_reg <= 1'b0;
      entry_reg <= '0;
      sched_owner_reg <= 1'b0;
      ind_owner_reg <= 1'b0;
      cm_cnt_reg <= '0;
      cm_write_reg <= 1'b0;
      lb_rom_reg <= 1'b0;
      lb_write_reg <= 1'b0;
      lb_be_reg <= '0;
      lb_lane_reg <= '0;
      lb_word_reg <= '0;
      push_reg <= 1'b0;
      push_slot_reg <= '0;
    end else begin
      push_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          host_ack <= 1'b0;
          if (host_req_valid && host_req.rom) begin
            if (!host_req.write) begin
              lb_rom_reg <= 1'b1;
              lb_write_reg <= 1'b0;
              lb_be_reg <= host_req.be;
              lb_word_reg <= host_req.addr[12:2];
              host_rdata <= '0;
              state_reg <= ST_LB_SETUP;
            end else begin
              state_reg <= ST_ACK;
              host_ack <= 1'b1;
            end
          end else if (host_req_valid && host_req.addr < PHY_LO) begin
            cm_addr <= host_req.addr[15:2];
            cm_wdata <= host_req.wdata;
            cm_write_reg <= host_req.write;
            sched_owner_reg <= 1'b0;
            ind_owner_reg <= 1'b0;
            cm_cnt_reg <= 3'(CM_ACCESS_CYCLES);
            state_reg <= ST_CM;
          end else if (host_req_valid && host_req.addr < USR_LO) begin
            lb_rom_reg <= 1'b0;
            lb_write_reg <= host_req.write;
            lb_be_reg <= host_req.write ? (4'h1 << low_lane(host_req.be))
                         : 4'h1;
            lb_lane_reg <= low_lane(host_req.be);
            lb_word_reg <= host_req.addr[12:2];
            lb_wdata <= host_req.wdata[8*low_lane(host_req.be) +: 8];
            state_reg <= ST_LB_SETUP;
          end else if (host_req_valid) begin
            host_rdata <= '0;
            state_reg <= ST_ACK;
            host_ack <= 1'b1;
            if (host_req.addr == REG_CM_DATA) begin
              cm_addr <= ind_addr_reg[13:0];
              cm_wdata <= host_req.wdata;
              cm_write_reg <= host_req.write;
              sched_owner_reg <= 1'b0;
              ind_owner_reg <= 1'b1;
              cm_cnt_reg <= 3'(CM_ACCESS_CYCLES);
              if (host_req.write) begin
                ind_data_reg <= host_req.wdata;
              end
              host_ack <= 1'b0;
              state_reg <= ST_CM;
            end else if (host_req.addr == REG_CM_ADDR) begin
              if (host_req.write) ind_addr_reg <= host_req.wdata;
              host_rdata <= ind_addr_reg;
            end else if (host_req.addr == REG_TBL_SIZE) begin
              if (host_req.write) begin
                tbl_size_reg <= (host_req.wdata[12:0] > TBL_MAX_ENTRIES)
                                ? TBL_MAX_ENTRIES : host_req.wdata[12:0];
                entry_reg <= '0;
              end
              host_rdata <= {19'd0, tbl_size_reg};
            end else if (host_req.addr == REG_SCHED_CTRL) begin
              if (host_req.write) sched_run_reg <= host_req.wdata[0];
              host_rdata <= {31'd0, sched_run_reg};
            end else if (host_req.addr == REG_SCHED_STAT) begin
              host_rdata <= {18'd0, fifo_in_ready, entry_reg};
            end
          end else if (sched_run_reg && fifo_in_ready
                       && tbl_size_reg != '0 && !push_reg) begin
            cm_addr <= CMB_TBL + {3'd0, entry_reg[12:2]};
            cm_write_reg <= 1'b0;
            sched_owner_reg <= 1'b1;
            ind_owner_reg <= 1'b0;
            cm_cnt_reg <= 3'(CM_ACCESS_CYCLES);
            state_reg <= ST_CM;
          end
        end
        ST_CM: begin
          cm_we_n <= !cm_write_reg;
          cm_data_oe <= cm_write_reg;
          cm_oe_n <= cm_write_reg;
          if (cm_cnt_reg != '0) begin
            cm_cnt_reg <= cm_cnt_reg - 3'd1;
          end else if (cm_write_reg || cm_data_ok) begin
            cm_we_n <= 1'b1;
            cm_data_oe <= 1'b0;
            cm_oe_n <= 1'b1;
            if (sched_owner_reg) begin
              push_reg <= 1'b1;
              push_slot_reg.idle <= (tbl_byte == 8'h00);
              push_slot_reg.aal5_encap <= (tbl_byte != 8'h00);
              push_slot_reg.bandwidth_group <= tbl_byte;
              entry_reg <= entry_next;
              state_reg <= ST_IDLE;
            end else begin
              if (!cm_write_reg) begin
                host_rdata <= cm_sync_reg[2];
                if (ind_owner_reg) ind_data_reg <= cm_sync_reg[2];
              end
              host_ack <= 1'b1;
              state_reg <= ST_ACK;
            end
          end
        end
        ST_LB_SETUP: begin
          if (lb_be_reg == '0) begin
            host_ack <= 1'b1;
            state_reg <= ST_ACK;
          end else begin
            lb_lane_reg <= lb_rom_reg ? low_lane(lb_be_reg) : lb_lane_reg;
            lb_addr <= {lb_word_reg,
                        lb_rom_reg ? low_lane(lb_be_reg) : lb_lane_reg};
            lb_rom_cs_n <= !lb_rom_reg;
            lb_phy_cs_n <= lb_rom_reg;
            lb_rd_n <= lb_write_reg;
            lb_wr_n <= !lb_write_reg;
            lb_data_oe <= lb_write_reg;
            state_reg <= ST_LB_WAIT;
          end
        end
        ST_LB_WAIT: begin
          if (lb_rdy_high && (lb_write_reg || lb_data_ok)) begin
            lb_rom_cs_n <= 1'b1;
            lb_phy_cs_n <= 1'b1;
            lb_rd_n <= 1'b1;
            lb_wr_n <= 1'b1;
            lb_data_oe <= 1'b0;
            if (lb_rom_reg) begin
              host_rdata[8*lb_lane_reg +: 8] <= lb_sync_reg[2];
              lb_be_reg[lb_lane_reg] <= 1'b0;
            end else begin
              if (!lb_write_reg) host_rdata <= {4{lb_sync_reg[2]}};
              lb_be_reg <= '0;
            end
            state_reg <= ST_LB_NEXT;
          end
        end
        ST_LB_NEXT: begin
          if (lb_rdy_low) state_reg <= ST_LB_SETUP;
        end
        ST_ACK: begin
          host_ack <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------
  // receive buffer alignment
  // --------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rx_buf_align_mask <= RX_ALIGN_MASK;
    else rx_buf_align_mask <= RX_ALIGN_MASK;
  end

  // --------
  // transmit slot buffer
  // --------
  slot_fifo #(
    .WIDTH($bits(cell_slot_type)),
    .DEPTH(SLOT_DEPTH)
  ) u_slot_fifo (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .in_valid(push_reg), .in_ready(fifo_in_ready),
    .in_data(push_slot_reg), .out_valid(cell_valid),
    .out_ready(cell_ready), .out_data(cell_slot)
  );

endmodule

`default_nettype wire

// ---- logic/sar_map_pkg.sv ----
// constants and types for the control-memory map and cell scheduler
`default_nettype none

package sar_map_pkg;

  // ----------------------------------------------------------------
  // host slave offset ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] INIT_LO = 16'h0000;
  localparam logic [15:0] INIT_HI = 16'h03FF;
  localparam logic [15:0] TXST_LO = 16'h0400;
  localparam logic [15:0] TXST_HI = 16'h23FF;
  localparam logic [15:0] TBL_LO = 16'h2400;
  localparam logic [15:0] TBL_HI = 16'h3FFF;
  localparam logic [15:0] RXST_LO = 16'h4000;
  localparam logic [15:0] RXST_HI = 16'hBFFF;
  localparam logic [15:0] PHY_LO = 16'hC000;
  localparam logic [15:0] PHY_HI = 16'hDFFF;
  localparam logic [15:0] USR_LO = 16'hE000;
  localparam logic [15:0] USR_HI = 16'hFFFF;

  // ----------------------------------------------------------------
  // control-memory word bases
  // ----------------------------------------------------------------
  localparam logic [13:0] CMB_INIT = 14'h0000;
  localparam logic [13:0] CMB_TXST = 14'h0100;
  localparam logic [13:0] CMB_TBL = 14'h0900;
  localparam logic [13:0] CMB_RXST = 14'h1000;

  // ----------------------------------------------------------------
  // internal user registers
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_CM_ADDR = 16'hE000;
  localparam logic [15:0] REG_CM_DATA = 16'hE004;
  localparam logic [15:0] REG_TBL_SIZE = 16'hE008;
  localparam logic [15:0] REG_SCHED_CTRL = 16'hE00C;
  localparam logic [15:0] REG_SCHED_STAT = 16'hE010;
  localparam logic [31:0] RST_CM_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_CM_DATA = 32'h0000_0000;
  localparam logic [12:0] RST_TBL_SIZE = 13'h0000;
  localparam logic [12:0] TBL_MAX_ENTRIES = 13'h12C0;
  localparam logic [3:0] RX_ALIGN_MASK = 4'hF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CM_ACCESS_CYCLES = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic rom;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic idle;
    logic aal5_encap;
    logic [7:0] bandwidth_group;
  } cell_slot_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CM = 3'b001,
    ST_LB_SETUP = 3'b010,
    ST_LB_WAIT = 3'b011,
    ST_LB_NEXT = 3'b100,
    ST_ACK = 3'b101
  } slave_state_type;

endpackage

`default_nettype wire

// ---- test/map_sched_checker.sv ----
// port assertions and covers for the map and cell scheduler
`default_nettype none
module map_sched_checker
  import sar_map_pkg::*;
#(
  parameter int SLOT_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic host_req_valid,
  input wire host_req_type host_req,
  input wire logic host_ack,
  input wire logic [31:0] host_rdata,
  input wire logic [13:0] cm_addr,
  input wire logic cm_we_n,
  input wire logic [12:0] lb_addr,
  input wire logic [7:0] lb_wdata,
  input wire logic lb_rd_n,
  input wire logic lb_wr_n,
  input wire logic lb_phy_cs_n,
  input wire logic lb_rom_cs_n,
  input wire logic lb_ready,
  input wire logic cell_valid,
  input wire cell_slot_type cell_slot,
  input wire logic cell_ready
);
  logic to_cm;
  logic to_phy;
  logic lb_on;
  assign to_cm = host_req_valid && !host_req.rom && host_req.addr < PHY_LO;
  assign to_phy = host_req_valid && !host_req.rom &&
    host_req.addr >= PHY_LO && host_req.addr <= PHY_HI;
  assign lb_on = !lb_rd_n || !lb_wr_n;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_pulse: assert property (host_ack |=> !host_ack)
    else $error("host_ack longer than one cycle");
  a_cm_no_early: assert property ($rose(to_cm) |-> !host_ack [*6])
    else $error("control-memory ack too early");
  a_cm_word_addr: assert property (to_cm && !cm_we_n |->
    cm_addr == host_req.addr[15:2])
    else $error("control-memory word address wrong");
  a_phy_rd_copy: assert property (host_ack && to_phy &&
    !host_req.write |-> host_rdata == {4{host_rdata[7:0]}})
    else $error("phy read byte not copied to all lanes");
  a_phy_wr_lane: assert property (!lb_wr_n |-> !lb_phy_cs_n &&
    host_req.be[lb_addr[1:0]] && lb_addr[12:2] == host_req.addr[12:2] &&
    lb_wdata == host_req.wdata[8*lb_addr[1:0] +: 8])
    else $error("phy write byte or lane wrong");
  a_rom_read_only: assert property (!lb_rom_cs_n |-> lb_wr_n)
    else $error("write strobe on rom");
  a_lb_wait_ready: assert property (lb_on && !lb_ready |=> lb_on)
    else $error("local-bus strobe dropped before ready");
  a_zero_idle: assert property (cell_valid |->
    cell_slot.idle == (cell_slot.bandwidth_group == 8'h00) &&
    cell_slot.aal5_encap == !cell_slot.idle)
    else $error("idle or encapsulation flag wrong");
  a_cell_held: assert property (cell_valid && !cell_ready |=>
    cell_valid && $stable(cell_slot))
    else $error("cell slot lost while stalled");
  c_phy_ready: cover property (!lb_wr_n && lb_ready);
  c_rom_read: cover property (!lb_rom_cs_n && !lb_rd_n);
  c_idle_cell: cover property (cell_valid && cell_ready && cell_slot.idle);
  c_stall: cover property (cell_valid && !cell_ready [*4]);
endmodule

bind ctrl_mem_map_and_cell_scheduler map_sched_checker #(
  .SLOT_DEPTH(SLOT_DEPTH)
) map_sched_checker_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .host_req_valid(host_req_valid),
  .host_req(host_req), .host_ack(host_ack), .host_rdata(host_rdata),
  .cm_addr(cm_addr), .cm_we_n(cm_we_n), .lb_addr(lb_addr),
  .lb_wdata(lb_wdata), .lb_rd_n(lb_rd_n), .lb_wr_n(lb_wr_n),
  .lb_phy_cs_n(lb_phy_cs_n), .lb_rom_cs_n(lb_rom_cs_n),
  .lb_ready(lb_ready), .cell_valid(cell_valid), .cell_slot(cell_slot),
  .cell_ready(cell_ready)
);
`default_nettype wire

// ---- test/sram_lb_model.sv ----
// control-memory sram and local-bus peripheral model
`default_nettype none
module sram_lb_model (
  input wire logic ref_clk,
  input wire logic [3:0] lat,
  input wire logic [13:0] cm_addr,
  input wire logic [31:0] cm_wdata,
  input wire logic cm_data_oe,
  input wire logic cm_we_n,
  input wire logic cm_oe_n,
  output logic [31:0] cm_rdata,
  input wire logic [12:0] lb_addr,
  input wire logic [7:0] lb_wdata,
  input wire logic lb_data_oe,
  input wire logic lb_rd_n,
  input wire logic lb_wr_n,
  input wire logic lb_phy_cs_n,
  input wire logic lb_rom_cs_n,
  output logic [7:0] lb_rdata,
  output logic lb_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cm_mem [16384];
  logic [7:0] phy_mem [8192];
  logic [7:0] rom_mem [8192];
  logic [31:0] cm_hold = 32'h0;
  logic [7:0] lb_hold = 8'h0;
  logic [3:0] wait_cnt = 4'h0;
  logic lb_act;
  initial lb_ready = 1'b0;
  assign lb_act = (!lb_rd_n || !lb_wr_n) && !(lb_phy_cs_n && lb_rom_cs_n);
  // released buses show the inverse of the last value
  assign cm_rdata = cm_data_oe ? cm_wdata :
    !cm_oe_n ? cm_mem[cm_addr] : ~cm_hold;
  assign lb_rdata = lb_data_oe ? lb_wdata :
    (!lb_rd_n && !lb_phy_cs_n) ? phy_mem[lb_addr] :
    (!lb_rd_n && !lb_rom_cs_n) ? rom_mem[lb_addr] : ~lb_hold;
  always @(posedge ref_clk) begin
    cm_hold <= cm_rdata;
    lb_hold <= lb_rdata;
    if (!cm_we_n && cm_data_oe) begin
      cm_mem[cm_addr] <= cm_wdata;
    end
    if (!lb_wr_n && !lb_phy_cs_n && lb_data_oe) begin
      phy_mem[lb_addr] <= lb_wdata;
    end
    wait_cnt <= !lb_act ? 4'h0 : (wait_cnt == 4'hF) ? wait_cnt :
      wait_cnt + 4'h1;
    lb_ready <= lb_act && wait_cnt >= lat;
  end
endmodule
`default_nettype wire

// ---- test/test_ctrl_mem_map_and_cell_scheduler.sv ----
// self-checking bench for the map and cell scheduler
`default_nettype none
module test_ctrl_mem_map_and_cell_scheduler
  import sar_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, host_req_valid, host_ack, cm_data_oe, cm_we_n;
  logic cm_oe_n, lb_data_oe, lb_rd_n, lb_wr_n, lb_phy_cs_n, lb_rom_cs_n;
  logic lb_ready, cell_valid, cell_ready, consume;
  logic [31:0] host_rdata, cm_wdata, cm_rdata;
  logic [13:0] cm_addr;
  logic [12:0] lb_addr;
  logic [7:0] lb_wdata, lb_rdata;
  logic [3:0] rx_buf_align_mask, lat;
  host_req_type host_req;
  cell_slot_type cell_slot;
  cell_slot_type got [$];
  int mismatches, cmp_count;

  ctrl_mem_map_and_cell_scheduler ctrl_mem_map_and_cell_scheduler_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .host_req_valid(host_req_valid),
    .host_req(host_req), .host_ack(host_ack), .host_rdata(host_rdata),
    .cm_addr(cm_addr), .cm_wdata(cm_wdata), .cm_data_oe(cm_data_oe),
    .cm_rdata(cm_rdata), .cm_we_n(cm_we_n), .cm_oe_n(cm_oe_n),
    .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_data_oe(lb_data_oe),
    .lb_rdata(lb_rdata), .lb_rd_n(lb_rd_n), .lb_wr_n(lb_wr_n),
    .lb_phy_cs_n(lb_phy_cs_n), .lb_rom_cs_n(lb_rom_cs_n),
    .lb_ready(lb_ready), .cell_valid(cell_valid), .cell_slot(cell_slot),
    .cell_ready(cell_ready), .rx_buf_align_mask(rx_buf_align_mask)
  );
  sram_lb_model sram_lb_model_i (
    .ref_clk(ref_clk), .lat(lat), .cm_addr(cm_addr), .cm_wdata(cm_wdata),
    .cm_data_oe(cm_data_oe), .cm_we_n(cm_we_n), .cm_oe_n(cm_oe_n),
    .cm_rdata(cm_rdata), .lb_addr(lb_addr), .lb_wdata(lb_wdata),
    .lb_data_oe(lb_data_oe), .lb_rd_n(lb_rd_n), .lb_wr_n(lb_wr_n),
    .lb_phy_cs_n(lb_phy_cs_n), .lb_rom_cs_n(lb_rom_cs_n),
    .lb_rdata(lb_rdata), .lb_ready(lb_ready)
  );

  // ----------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [9:0] exp_slot(input logic [7:0] b);
    return {b == 8'h00, b != 8'h00, b};
  endfunction
  // one host transfer, held until the acknowledge is seen
  task automatic host(input logic wr, rom, input logic [15:0] a,
    input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    host_req_valid = 1'b1;
    host_req = '{write: wr, rom: rom, addr: a, be: be, wdata: wd};
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (host_ack !== 1'b1 && n < 2000);
    rd = host_rdata;
    check("host_ack", host_ack, 32'h1);
    @(posedge ref_clk);
    #1;
    host_req_valid = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    host(1'b1, 1'b0, a, 4'hF, d, x);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] x);
    host(1'b0, 1'b0, a, 4'hF, 32'h0, x);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    mismatches++;
    stop_test();
  end
  always @(posedge ref_clk) begin
    cell_ready <= consume && ($urandom_range(3) != 0);
    if (cell_valid === 1'b1 && cell_ready === 1'b1) begin
      got.push_back(cell_slot);
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] lo [4] = '{INIT_LO, TXST_LO, TBL_LO, RXST_LO};
    logic [15:0] hi [4] = '{INIT_HI, TXST_HI, TBL_HI, RXST_HI};
    logic [13:0] bs [4] = '{CMB_INIT, CMB_TXST, CMB_TBL, CMB_RXST};
    logic [7:0] tbl [8];
    logic [31:0] d, e;
    logic [15:0] a;
    logic [13:0] w;
    logic [12:0] p;
    logic [7:0] b;
    logic [3:0] be;
    int n, g0;
    rst_n = 1'b0;
    host_req_valid = 1'b0;
    host_req = '0;
    consume = 1'b0;
    cell_ready = 1'b0;
    lat = 4'h0;
    void'($urandom(32'hB9AC039D));
    repeat (3) @(posedge ref_clk);
    check("reset strobes", {24'h0, host_ack, cell_valid, cm_we_n, cm_oe_n,
      lb_rd_n, lb_wr_n, lb_phy_cs_n, lb_rom_cs_n}, 32'h3F);
    #1 rst_n = 1'b1;
    @(posedge ref_clk);
    #1;
    check("align mask", rx_buf_align_mask, 32'hF);
    rd(REG_CM_ADDR, e);
    check("cm addr reset", e, RST_CM_ADDR);
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 3; k++) begin
        a = (k == 0) ? lo[r] : (k == 1) ? hi[r] - 16'h3 :
          (lo[r] + 16'($urandom_range(hi[r] - lo[r]))) & 16'hFFFC;
        d = $urandom;
        wr(a, d);
        w = bs[r] + 14'((a - lo[r]) >> 2);
        check("cm word", sram_lb_model_i.cm_mem[w], d);
        rd(a, e);
        check("cm read", e, d);
      end
    end
    w = 14'($urandom);
    wr(REG_CM_ADDR, {18'h0, w});
    rd(REG_CM_ADDR, e);
    check("indirect addr", e, {18'h0, w});
    d = $urandom;
    wr(REG_CM_DATA, d);
    check("indirect write", sram_lb_model_i.cm_mem[w], d);
    sram_lb_model_i.cm_mem[w] = ~d;
    rd(REG_CM_DATA, e);
    check("indirect read", e, ~d);
    for (int l = 0; l < 4; l++) begin
      lat = 4'($urandom_range(6));
      a = (PHY_LO + 16'($urandom_range(16'h1FFF))) & 16'hFFFC;
      p = {a[12:2], 2'(l)};
      d = $urandom;
      host(1'b1, 1'b0, a, 4'h1 << l, d, e);
      check("phy write", sram_lb_model_i.phy_mem[p],
        d[8*l +: 8]);
      b = 8'($urandom);
      sram_lb_model_i.phy_mem[p] = b;
      host(1'b0, 1'b0, a, 4'h1 << l, 32'h0, e);
      check("phy read", e, {4{b}});
    end
    for (int k = 0; k < 6; k++) begin
      lat = 4'($urandom_range(6));
      a = 16'($urandom) & 16'h1FFC;
      be = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($urandom);
      e = 32'h0;
      for (int l = 0; l < 4; l++) begin
        b = 8'($urandom);
        sram_lb_model_i.rom_mem[{a[12:2], 2'(l)}] = b;
        if (be[l]) begin
          e[8*l +: 8] = b;
        end
      end
      host(1'b0, 1'b1, a, be, 32'h0, d);
      check("rom read", d, e);
    end
    rd(16'hE0F0, e);
    check("unmapped user", e, 32'h0);
    wr(REG_TBL_SIZE, 32'h1FFF);
    rd(REG_TBL_SIZE, e);
    check("size clamp", e, {19'h0, TBL_MAX_ENTRIES});
    for (int i = 0; i < 8; i++) begin
      tbl[i] = (i % 3 == 2) ? 8'h00 : 8'($urandom_range(255, 1));
    end
    wr(TBL_LO, {tbl[3], tbl[2], tbl[1], tbl[0]});
    wr(TBL_LO + 16'h4, {tbl[7], tbl[6], tbl[5], tbl[4]});
    wr(REG_TBL_SIZE, 32'h6);
    rd(REG_TBL_SIZE, e);
    check("table size", e, 32'h6);
    wr(REG_SCHED_CTRL, 32'h1);
    consume = 1'b1;
    n = 0;
    while (got.size() < 20 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    #1 consume = 1'b0;
    n = 0;
    do begin
      rd(REG_SCHED_STAT, e);
      n++;
    end while (e[13] !== 1'b0 && n < 20);
    check("fifo full", e[13], 32'h0);
    g0 = got.size();
    wr(REG_SCHED_CTRL, 32'h0);
    consume = 1'b1;
    n = 0;
    while (cell_valid !== 1'b0 && n < 500) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("fifo depth", got.size() - g0 >= 8, 32'h1);
    rd(REG_SCHED_STAT, e);
    check("fifo space", e[13], 32'h1);
    for (int i = 0; i < got.size(); i++) begin
      check("cell slot", got[i],
        exp_slot(tbl[i % 6]));
    end
    stop_test();
  end
endmodule
`default_nettype wire
